// ---- hw/upstream_fragmenter.sv ----
/*
  Upstream fragmenter with service flow element build and parse.
  Assumes frame bytes, grants and parsed elements come from logic on the
  same clock, and a register master that never issues read and write at once.
*/
// Implementation choices: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
// Notes on behaviour
// - Suppression element: type 5 down, 6 up, len 1
// - Index 0 or no element: no suppression
// - Suppressed strings up to 255 bytes handled
// - Upstream suppression starts right after checksum
// - Downstream suppression starts thirteenth byte after checksum
// - Packet CRC sent unless whole PDU suppressed
// - Unfragmented privacy starts at thirteenth byte
// - Grant sync element: type 6, length 2
// - Short grant starts fragmentation when enabled
// - Fragment payload is grant minus overhead
// - Fragment header control byte type 11, 00011
// - Sequence starts anywhere, steps by one, wraps
// - First flag first only, last flag last only
// - Last fragment request asks for next frame
// - Fixed 16-byte overhead, privacy element always
// - Privacy fields copied, enable cleared without privacy
// - Service id taken from initiating partial grant
// - Separate CRC appended to each fragment
// - Fragmented privacy starts after checksum
// - No key messages concatenated under full privacy
// - Fragment element value field layout
module upstream_fragmenter
  import frag_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  input wire logic [7:0] in_data_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic grant_valid_in,
  input wire logic [15:0] grant_len_in,
  input wire logic [13:0] grant_sid_in,
  output logic [7:0] tx_data_out,
  output logic tx_valid_out,
  output logic tx_last_out,
  input wire logic tx_ready_in,
  input wire logic key_msg_in,
  output logic concat_ok_out,
  output logic [23:0] sf_elem_out,
  output logic sf_elem_valid_out,
  input wire logic rx_pkt_in,
  input wire logic rx_elem_present_in,
  input wire logic [7:0] rx_elem_hdr_in,
  input wire logic [7:0] rx_elem_val_in,
  output logic [7:0] rx_index_out,
  output logic [3:0] crypt_start_out,
  output logic [3:0] us_supp_start_out,
  output logic [3:0] ds_supp_start_out,
  output logic pkt_crc_send_out,
  output logic frag_active_out
);
  // ****************************************
  // Declarations
  // ****************************************
  fr_state_t state;
  logic [31:0] ctrl;
  logic [31:0] priv;
  logic [31:0] supp;
  logic [31:0] frame;
  logic [15:0] remaining;
  logic [15:0] chunk_cnt;
  logic [15:0] frag_len;
  logic [3:0] idx;
  logic [3:0] seq;
  logic [13:0] service_identifier;
  logic first_flag;
  logic last_flag;
  logic framed;
  logic frag_active;
  logic [15:0] header_checksum;
  logic [31:0] fragment_crc;
  logic can_load;
  logic emit;
  logic grant_take;
  logic grant_short;
  logic [15:0] grant_room;
  logic [7:0] next_byte;
  logic next_last;
  logic frag_en;
  logic priv_en;

  function automatic logic [15:0] hcs_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      r = {r[14:0], 1'b0} ^ ((r[15] ^ d[i]) ? HCS_POLY : 16'h0000);
    end
    return r;
  endfunction : hcs_step

  function automatic logic [31:0] fragment_crc_step(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      r = {r[30:0], 1'b0} ^ ((r[31] ^ d[i]) ? FRAGMENT_CRC_POLY : 32'h0000_0000);
    end
    return r;
  endfunction : fragment_crc_step

  assign frag_en = ctrl[CTRL_FRAG_BIT];
  assign priv_en = ctrl[CTRL_PRIV_BIT];
  assign frag_active_out = frag_active;

  // ****************************************
  // Register port
  // ****************************************
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl <= CTRL_RESET;
      priv <= PRIV_RESET;
      supp <= SUPP_RESET;
      frame <= FRAME_RESET;
    end else if (reg_wr_in) begin
      if (reg_addr_in == CTRL_OFS) ctrl <= reg_wdata_in;
      if (reg_addr_in == PRIV_OFS) priv <= reg_wdata_in;
      if (reg_addr_in == SUPP_OFS) supp <= reg_wdata_in;
      if (reg_addr_in == FRAME_OFS) frame <= reg_wdata_in;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 32'h0000_0000;
    end else if (reg_rd_in) begin
      unique case (reg_addr_in)
        CTRL_OFS: reg_rdata_out <= ctrl;
        PRIV_OFS: reg_rdata_out <= priv;
        SUPP_OFS: reg_rdata_out <= supp;
        STAT_OFS: reg_rdata_out <= {16'h0000, remaining};
        FRAME_OFS: reg_rdata_out <= {frame[31:16], 4'h0, seq, 6'h00, state};
        default: reg_rdata_out <= 32'h0000_0000;
      endcase
      if (reg_addr_in == STAT_OFS) begin
        reg_rdata_out[31] <= frag_active;
      end
    end else begin
      reg_rdata_out <= 32'h0000_0000;
    end
  end

  // ****************************************
  // Service flow element and offsets
  // ****************************************
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sf_elem_out <= 24'h000000;
      sf_elem_valid_out <= 1'b0;
    end else if (ctrl[CTRL_UGS_BIT]) begin
      sf_elem_out <= {SF_TYPE_UP, SF_LEN_UGS, supp[7:0], supp[SUPP_QUEUE_BIT], supp[15:9]};
      sf_elem_valid_out <= 1'b1;
    end else begin
      sf_elem_out <= {SF_TYPE_UP, SF_LEN_SUPP, supp[7:0], 8'h00};
      sf_elem_valid_out <= (supp[7:0] != NO_SUPPRESS);
    end
  end

  // Unknown or malformed elements fall back to no suppression
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_index_out <= NO_SUPPRESS;
    end else if (rx_pkt_in) begin
      if (rx_elem_present_in && rx_elem_hdr_in == {SF_TYPE_DOWN, SF_LEN_SUPP}) begin
        rx_index_out <= rx_elem_val_in;
      end else begin
        rx_index_out <= NO_SUPPRESS;
      end
    end
  end

  assign us_supp_start_out = US_SUPP_START;
  assign ds_supp_start_out = DS_SUPP_START;
  assign crypt_start_out = frag_active ? CRYPT_START_FRAG : CRYPT_START_PLAIN;
  // CRC is dropped only when the suppressed string covers the whole frame
  assign pkt_crc_send_out = (supp[7:0] == NO_SUPPRESS) ||
                            ({8'h00, supp[SUPP_LEN_LSB+:8]} < frame[15:0]);
  assign concat_ok_out = !(frag_en && priv_en && ctrl[CTRL_CONCAT_BIT] && key_msg_in);

  // ****************************************
  // Grant decision
  // ****************************************
  assign can_load = !tx_valid_out || tx_ready_in;
  assign grant_room = grant_len_in - FRAG_OVERHEAD;
  assign grant_short = grant_len_in < remaining;
  // Fragmenting grants under the minimum are ignored rather than risk an empty fragment
  assign grant_take = (state == ST_IDLE) && grant_valid_in && (remaining != 16'h0000) &&
                      (frag_active ? (grant_len_in >= FRAG_MIN_GRANT) :
                       (!grant_short || (frag_en && grant_len_in >= FRAG_MIN_GRANT)));
  assign emit = can_load && ((state == ST_HDR) || (state == ST_CRC) ||
                             ((state == ST_BODY) && in_valid_in));
  assign in_ready_out = can_load && (state == ST_BODY);

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      framed <= 1'b0;
      first_flag <= 1'b0;
      last_flag <= 1'b0;
      chunk_cnt <= 16'h0000;
      frag_len <= 16'h0000;
    end else if (grant_take) begin
      if (frag_active) begin
        framed <= 1'b1;
        first_flag <= 1'b0;
        last_flag <= (grant_room >= remaining);
        chunk_cnt <= (grant_room >= remaining) ? remaining : grant_room;
        frag_len <= FRAGMENT_CRC_LEN + {8'h00, FRAG_EXTENDED_HEADER_LEN} +
                    ((grant_room >= remaining) ? remaining : grant_room);
      end else if (grant_short) begin
        framed <= 1'b1;
        first_flag <= 1'b1;
        last_flag <= 1'b0;
        chunk_cnt <= grant_room;
        frag_len <= FRAGMENT_CRC_LEN + {8'h00, FRAG_EXTENDED_HEADER_LEN} + grant_room;
      end else begin
        framed <= 1'b0;
        first_flag <= 1'b0;
        last_flag <= 1'b0;
        chunk_cnt <= remaining;
        frag_len <= remaining;
      end
    end else if (emit && state == ST_BODY) begin
      chunk_cnt <= chunk_cnt - 16'h0001;
    end
  end

  // Service id stays with the grant that opened the fragment run
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      service_identifier <= 14'h0000;
    end else if (grant_take && !frag_active && grant_short) begin
      service_identifier <= grant_sid_in;
    end
  end

  // ****************************************
  // Frame sequencing
  // ****************************************
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= ST_IDLE;
      idx <= 4'h0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          idx <= 4'h0;
          if (grant_take) state <= (frag_active || grant_short) ? ST_HDR : ST_BODY;
        end
        ST_HDR: if (emit) begin
          idx <= (idx == HDR_LAST_IDX) ? 4'h0 : idx + 4'h1;
          if (idx == HDR_LAST_IDX) state <= ST_BODY;
        end
        ST_BODY: if (emit && chunk_cnt == 16'h0001) begin
          state <= framed ? ST_CRC : ST_IDLE;
        end
        ST_CRC: if (emit) begin
          idx <= idx + 4'h1;
          if (idx == 4'h3) state <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      remaining <= 16'h0000;
    end else if (reg_wr_in && reg_addr_in == FRAME_OFS && state == ST_IDLE && !frag_active) begin
      remaining <= reg_wdata_in[15:0];
    end else if (emit && state == ST_BODY) begin
      remaining <= remaining - 16'h0001;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      frag_active <= 1'b0;
    end else if (grant_take && !frag_active && grant_short) begin
      frag_active <= 1'b1;
    end else if (emit && state == ST_CRC && idx == 4'h3 && last_flag) begin
      frag_active <= 1'b0;
    end
  end

  // No reset of the count between frames: any start value is legal
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      seq <= 4'h0;
    end else if (emit && state == ST_CRC && idx == 4'h3) begin
      seq <= seq + 4'h1;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      header_checksum <= 16'hFFFF;
      fragment_crc <= 32'hFFFF_FFFF;
    end else if (grant_take) begin
      header_checksum <= 16'hFFFF;
      fragment_crc <= 32'hFFFF_FFFF;
    end else if (emit && state == ST_HDR && idx < HCS_HI_IDX) begin
      header_checksum <= hcs_step(header_checksum, next_byte);
    end else if (emit && state == ST_BODY && framed) begin
      fragment_crc <= fragment_crc_step(fragment_crc, next_byte);
    end
  end

  // ****************************************
  // Byte selection
  // ****************************************
  always_comb begin
    next_byte = in_data_in;
    unique case (state)
      ST_HDR: begin
        unique case (idx)
          4'h0: next_byte = FC_FRAG;
          4'h1: next_byte = FRAG_EXTENDED_HEADER_LEN;
          4'h2: next_byte = frag_len[15:8];
          4'h3: next_byte = frag_len[7:0];
          4'h4: next_byte = {PRIV_EXT_ELEMENT_TYPE, PRIV_EH_FRAG_LEN};
          4'h5: next_byte = {priv[3:0], priv[7:4]};
          4'h6: next_byte = {priv_en, priv[PRIV_TOGGLE_BIT] & priv_en, service_identifier[13:8]};
          4'h7: next_byte = service_identifier[7:0];
          4'h8: next_byte = frame[FRAME_REQ_LSB+:8];
          4'h9: next_byte = {2'b00, first_flag, last_flag, seq};
          4'hA: next_byte = ~header_checksum[15:8];
          default: next_byte = ~header_checksum[7:0];
        endcase
      end
      ST_CRC: next_byte = ~fragment_crc[8'd31 - {idx[1:0], 3'b000} -: 8];
      default: next_byte = in_data_in;
    endcase
  end

  assign next_last = ((state == ST_BODY) && !framed && chunk_cnt == 16'h0001) ||
                     ((state == ST_CRC) && idx == 4'h3);

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_valid_out <= 1'b0;
      tx_data_out <= 8'h00;
      tx_last_out <= 1'b0;
    end else if (can_load) begin
      tx_valid_out <= emit;
      tx_data_out <= emit ? next_byte : 8'h00;
      tx_last_out <= emit && next_last;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_fc_type_byte: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (emit && state == ST_HDR && idx == 4'h0) |=> (tx_data_out == 8'hE3))
    else $error("fragment header control byte wrong");

  a_priv_elem_head: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (emit && state == ST_HDR && idx == 4'h4) |=> (tx_data_out == 8'h35))
    else $error("fragment element type or length wrong");

  a_seq_step_one: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (emit && state == ST_CRC && idx == 4'h3) |=> (seq == $past(seq) + 4'h1))
    else $error("fragment sequence did not step by one");

  a_flags_exclusive: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (emit && state == ST_HDR && idx == 4'h9) |=>
      (tx_data_out[5:4] != 2'b11) && (tx_data_out[7:6] == 2'b00))
    else $error("first and last flags both set");

  a_sid_held: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (frag_active && $past(frag_active)) |-> $stable(service_identifier))
    else $error("service id changed inside a fragment run");

  a_priv_clear: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (emit && state == ST_HDR && idx == 4'h6 && !priv_en) |=> (tx_data_out[7] == 1'b0))
    else $error("privacy enable set without privacy");

  a_short_splits: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (grant_take && !frag_active && grant_short) |=> frag_active ##1 (state == ST_HDR))
    else $error("short grant did not start fragmentation");

  a_chunk_fits: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (grant_take && !frag_active && grant_short) |=>
      (chunk_cnt == $past(grant_len_in) - 16'h0010))
    else $error("fragment payload does not fit grant");

  a_key_no_concat: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (ctrl[2:0] == 3'b111 && key_msg_in) |-> !concat_ok_out)
    else $error("key message allowed into concatenation");

  a_rx_no_elem: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (rx_pkt_in && !rx_elem_present_in) |=> (rx_index_out == 8'h00))
    else $error("missing element did not clear suppression");
endmodule : upstream_fragmenter

// ---- hw/frag_pkg.sv ----
/*
  Shared constants for the upstream fragmenter and suppression element logic:
  register offsets, field positions, header encodings and reset values.
  Assumes a single 50 MHz MAC clock domain.
*/
package frag_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] PRIV_OFS = 8'h04;
  localparam logic [7:0] SUPP_OFS = 8'h08;
  localparam logic [7:0] STAT_OFS = 8'h0C;
  localparam logic [7:0] FRAME_OFS = 8'h10;
  localparam int CTRL_FRAG_BIT = 0;
  localparam int CTRL_PRIV_BIT = 1;
  localparam int CTRL_CONCAT_BIT = 2;
  localparam int CTRL_UGS_BIT = 3;
  localparam int PRIV_TOGGLE_BIT = 8;
  localparam int SUPP_QUEUE_BIT = 8;
  localparam int SUPP_LEN_LSB = 16;
  localparam int FRAME_REQ_LSB = 16;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] PRIV_RESET = 32'h0000_0010;
  localparam logic [31:0] SUPP_RESET = 32'h0000_0000;
  localparam logic [31:0] FRAME_RESET = 32'h0000_0000;

  // ****************************************
  // Extended header elements
  // ****************************************
  localparam logic [3:0] SF_TYPE_DOWN = 4'h5;
  localparam logic [3:0] SF_TYPE_UP = 4'h6;
  localparam logic [3:0] SF_LEN_SUPP = 4'h1;
  localparam logic [3:0] SF_LEN_UGS = 4'h2;
  localparam logic [7:0] NO_SUPPRESS = 8'h00;
  localparam int SUPP_MIN_BYTES = 64;
  localparam int SUPP_MAX_BYTES = 255;
  localparam logic [3:0] US_SUPP_START = 4'h1;
  localparam logic [3:0] DS_SUPP_START = 4'hD;
  localparam logic [3:0] CRYPT_START_FRAG = 4'h1;
  localparam logic [3:0] CRYPT_START_PLAIN = 4'hD;

  // ****************************************
  // Fragment header
  // ****************************************
  localparam logic [7:0] FC_FRAG = 8'hE3;
  localparam logic [3:0] PRIV_EXT_ELEMENT_TYPE = 4'h3;
  localparam logic [3:0] PRIV_EH_FRAG_LEN = 4'h5;
  localparam logic [7:0] FRAG_EXTENDED_HEADER_LEN = 8'h06;
  localparam logic [15:0] FRAGMENT_CRC_LEN = 16'h0004;
  localparam logic [15:0] FRAG_OVERHEAD = 16'h0010;
  localparam logic [15:0] FRAG_MIN_GRANT = 16'h0011;
  localparam logic [3:0] HDR_LAST_IDX = 4'hB;
  localparam logic [3:0] HCS_HI_IDX = 4'hA;
  localparam logic [15:0] HCS_POLY = 16'h1021;
  localparam logic [31:0] FRAGMENT_CRC_POLY = 32'h04C1_1DB7;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HDR = 2'b01,
    ST_BODY = 2'b10,
    ST_CRC = 2'b11
  } fr_state_t;
endpackage : frag_pkg

// ---- tb/headend_model.sv ----
/*
  Headend terminal model: paces the fragment stream and tracks sequences.
  Assumes the fragmenter's tx handshake on the same clock.
*/
`timescale 1ns/10ps
module headend_model (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] tx_data_in,
  input wire logic tx_valid_in,
  input wire logic tx_last_in,
  input wire logic slow_in,
  output logic tx_ready_out,
  output logic seq_err_out,
  output logic [7:0] frag_cnt_out
);
  // ****************************************
  // Pacing and sequence tracking
  // ****************************************
  int seed = 96;
  int r;
  logic [3:0] idx;
  logic [7:0] first_byte;
  logic [3:0] seq_q;
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_ready_out <= 1'b0;
      seq_err_out <= 1'b0;
      frag_cnt_out <= 8'h00;
      idx <= 4'h0;
      first_byte <= 8'h00;
      seq_q <= 4'h0;
    end else begin
      r = $random(seed);
      // Slow mode stalls about half the cycles
      tx_ready_out <= !slow_in || r[0];
      if (tx_valid_in && tx_ready_out) begin
        if (idx == 4'h0) first_byte <= tx_data_in;
        if (idx == 4'h9 && first_byte == 8'hE3) begin
          frag_cnt_out <= frag_cnt_out + 8'h01;
          seq_q <= tx_data_in[3:0];
          if (!tx_data_in[5] && tx_data_in[3:0] != seq_q + 4'h1) seq_err_out <= 1'b1;
        end
        idx <= tx_last_in ? 4'h0 : (idx == 4'hF ? idx : idx + 4'h1);
      end
    end
  end
endmodule : headend_model

// ---- tb/upstream_fragmenter_and_suppressor_bench.sv ----
/*
  Self-checking bench for the upstream fragmenter.
  Assumes the headend model as sink and a 50 MHz clock.
*/
`timescale 1ns/10ps
`define CHK(nm, got, exp) begin cmp_count++; if ((got) !== (exp)) begin error_cnt++; \
  $display("mismatch %s expected %h seen %h", nm, exp, got); end end
module upstream_fragmenter_and_suppressor_bench
  import frag_pkg::*;
;
  // ****************************************
  // Signals
  // ****************************************
  logic sys_clk_in = 1'b0;
  logic rst_n_in, reg_wr_in, reg_rd_in, in_valid_in, grant_valid_in, tx_ready_in, key_msg_in;
  logic rx_pkt_in, rx_elem_present_in, tx_valid_out, tx_last_out, in_ready_out, concat_ok_out;
  logic sf_elem_valid_out, pkt_crc_send_out, frag_active_out, seq_err, slow, rd_d, tg, pe;
  logic [7:0] reg_addr_in, in_data_in, tx_data_out, rx_elem_hdr_in, rx_elem_val_in, rx_index_out;
  logic [7:0] frag_cnt, req, idx;
  logic [31:0] reg_wdata_in, reg_rdata_out, v, rexp;
  logic [15:0] grant_len_in, rem, pl;
  logic [13:0] grant_sid_in, sid0;
  logic [23:0] sf_elem_out, sf_exp;
  logic [3:0] crypt_start_out, us_supp_start_out, ds_supp_start_out;
  logic [16:0] exq[$], e;
  logic [31:0] rq[$];
  int error_cnt = 0, cmp_count = 0, seed = 96, feed_n = 0, feed_cnt = 0, cyc = 0, i, k;
  bit feed_frag;
  always #10 sys_clk_in = ~sys_clk_in;
  upstream_fragmenter dut_u (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .in_data_in(in_data_in),
    .in_valid_in(in_valid_in), .in_ready_out(in_ready_out), .grant_valid_in(grant_valid_in),
    .grant_len_in(grant_len_in), .grant_sid_in(grant_sid_in), .tx_data_out(tx_data_out),
    .tx_valid_out(tx_valid_out), .tx_last_out(tx_last_out), .tx_ready_in(tx_ready_in),
    .key_msg_in(key_msg_in), .concat_ok_out(concat_ok_out), .sf_elem_out(sf_elem_out),
    .sf_elem_valid_out(sf_elem_valid_out), .rx_pkt_in(rx_pkt_in),
    .rx_elem_present_in(rx_elem_present_in), .rx_elem_hdr_in(rx_elem_hdr_in),
    .rx_elem_val_in(rx_elem_val_in), .rx_index_out(rx_index_out),
    .crypt_start_out(crypt_start_out), .us_supp_start_out(us_supp_start_out),
    .ds_supp_start_out(ds_supp_start_out), .pkt_crc_send_out(pkt_crc_send_out),
    .frag_active_out(frag_active_out));
  headend_model he_u (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .tx_data_in(tx_data_out),
    .tx_valid_in(tx_valid_out), .tx_last_in(tx_last_out), .slow_in(slow),
    .tx_ready_out(tx_ready_in), .seq_err_out(seq_err), .frag_cnt_out(frag_cnt));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic close_out;
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] d);
    rq.push_back(d);
    @(posedge sys_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b0;
  endtask : rd
  task automatic grant(input logic [15:0] len, input logic [13:0] service_identifier);
    @(posedge sys_clk_in);
    grant_valid_in <= 1'b1;
    grant_len_in <= len;
    grant_sid_in <= service_identifier;
    @(posedge sys_clk_in);
    grant_valid_in <= 1'b0;
  endtask : grant
  task automatic drain;
    for (k = 0; k < 3000 && !(feed_cnt == feed_n && exq.size() == 0); k++) @(posedge sys_clk_in);
    `CHK("drain_done", k < 3000, 1'b1)
    if (k == 3000) close_out();
    repeat (3) @(posedge sys_clk_in);
  endtask : drain
  function automatic void push(input logic [7:0] m, input logic l, input logic [7:0] d);
    exq.push_back({m, l, d & m});
  endfunction : push
  // Sequence nibble left open here, the sink tracks its steps
  task automatic frag(input logic [15:0] len, input logic [13:0] gsid, input logic f,
                      input logic l);
    pl = l ? rem : len - 16'h0010;
    if (f) sid0 = gsid;
    push(8'hFF, 1'b0, 8'hE3);
    push(8'hFF, 1'b0, 8'h06);
    push(8'hFF, 1'b0, 8'((pl + 16'h000A) >> 8));
    push(8'hFF, 1'b0, 8'(pl + 16'h000A));
    push(8'hFF, 1'b0, 8'h35);
    push(8'hFF, 1'b0, 8'h51);
    push(8'hFF, 1'b0, {pe, tg, sid0[13:8]});
    push(8'hFF, 1'b0, sid0[7:0]);
    push(8'hFF, 1'b0, req);
    push(8'hF0, 1'b0, {2'b00, f, l, 4'h0});
    push(8'h00, 1'b0, 8'h00);
    push(8'h00, 1'b0, 8'h00);
    feed_cnt = 0;
    feed_n = int'(pl);
    feed_frag = 1'b1;
    grant(len, gsid);
    drain();
    rem = rem - pl;
  endtask : frag
  // ****************************************
  // Feeder, monitor and timeout
  // ****************************************
  always @(posedge sys_clk_in) begin
    if (rst_n_in && in_valid_in && in_ready_out) begin
      feed_cnt++;
      push(8'hFF, !feed_frag && feed_cnt == feed_n, in_data_in);
      if (feed_frag && feed_cnt == feed_n)
        for (int j = 0; j < 4; j++) push(8'h00, j == 3, 8'h00);
      // Top bit clear so a payload never looks like a fragment header
      in_data_in <= 8'($random(seed)) & 8'h7F;
    end
  end
  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      close_out();
    end
    rd_d <= reg_rd_in;
    if (rd_d) begin
      rexp = rq.pop_front();
      `CHK("reg_rdata", reg_rdata_out, rexp)
    end
    if (rst_n_in && tx_valid_out && tx_ready_in) begin
      if (exq.size() == 0) `CHK("tx_spare", 1'b0, 1'b1)
      e = (exq.size() == 0) ? 17'h1FFFF : exq.pop_front();
      `CHK("tx_data", tx_data_out & e[16:9], e[7:0])
      `CHK("tx_last", tx_last_out, e[8])
    end
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {rst_n_in, reg_wr_in, reg_rd_in, grant_valid_in, key_msg_in, rx_pkt_in, slow} = '0;
    {rx_elem_present_in, reg_addr_in, reg_wdata_in, grant_len_in, grant_sid_in} = '0;
    {rx_elem_hdr_in, rx_elem_val_in, in_data_in} = '0;
    in_valid_in = 1'b1;
    repeat (6) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    rd(CTRL_OFS, CTRL_RESET);
    rd(PRIV_OFS, PRIV_RESET);
    rd(SUPP_OFS, SUPP_RESET);
    rd(STAT_OFS, 32'h0000_0000);
    rd(8'h14, 32'h0000_0000);
    `CHK("us_start", us_supp_start_out, 4'h1)
    `CHK("ds_start", ds_supp_start_out, 4'hD)
    `CHK("crypt_start", crypt_start_out, 4'hD)
    `CHK("pkt_crc", pkt_crc_send_out, 1'b1)
    for (i = 0; i < 3; i++) begin
      v = $random(seed);
      idx = (i == 2) ? 8'h00 : (v[7:0] | 8'h01);
      wr(SUPP_OFS, {16'h0000, v[15:9], v[8], idx});
      wr(CTRL_OFS, {28'h0000000, i[0], 3'b000});
      repeat (2) @(posedge sys_clk_in);
      sf_exp = i[0] ? {8'h62, idx, v[8], v[15:9]} : {8'h61, idx, 8'h00};
      `CHK("sf_elem", sf_elem_out, sf_exp)
      `CHK("sf_valid", sf_elem_valid_out, i[0] | (idx != 8'h00))
    end
    for (i = 0; i < 3; i++) begin
      v = $random(seed);
      @(posedge sys_clk_in);
      rx_pkt_in <= 1'b1;
      rx_elem_present_in <= (i != 1);
      rx_elem_hdr_in <= 8'h51;
      rx_elem_val_in <= (i == 2) ? 8'h00 : (v[7:0] | 8'h01);
      @(posedge sys_clk_in);
      rx_pkt_in <= 1'b0;
      @(posedge sys_clk_in);
      `CHK("rx_index", rx_index_out, (i == 0) ? (v[7:0] | 8'h01) : 8'h00)
    end
    wr(FRAME_OFS, 32'h002A_003C);
    wr(CTRL_OFS, 32'h0000_0000);
    grant(16'h001E, 14'h0123);
    repeat (8) @(posedge sys_clk_in);
    `CHK("tx_valid", tx_valid_out, 1'b0)
    wr(PRIV_OFS, 32'h0000_0115);
    wr(CTRL_OFS, 32'h0000_0003);
    grant(16'h0010, 14'h0123);
    repeat (8) @(posedge sys_clk_in);
    `CHK("tx_valid", tx_valid_out, 1'b0)
    {rem, req, pe, tg} = {16'h003C, 8'h2A, 2'b11};
    frag(16'h0011, 14'h0123, 1'b1, 1'b0);
    `CHK("frag_active", frag_active_out, 1'b1)
    `CHK("crypt_start", crypt_start_out, 4'h1)
    frag(16'h0024, 14'h0456, 1'b0, 1'b0);
    frag(16'h0037, 14'h0789, 1'b0, 1'b1);
    `CHK("frag_active", frag_active_out, 1'b0)
    `CHK("crypt_start", crypt_start_out, 4'hD)
    slow <= 1'b1;
    wr(CTRL_OFS, 32'h0000_0001);
    wr(FRAME_OFS, 32'h0007_0014);
    {rem, req, pe, tg} = {16'h0014, 8'h07, 2'b00};
    frag(16'h0013, 14'h00AB, 1'b1, 1'b0);
    frag(16'h0021, 14'h00CD, 1'b0, 1'b1);
    `CHK("frag_cnt", frag_cnt, 8'h05)
    `CHK("seq_err", seq_err, 1'b0)
    wr(FRAME_OFS, 32'h0000_0005);
    feed_cnt = 0;
    feed_n = 5;
    feed_frag = 1'b0;
    grant(16'h0005, 14'h0011);
    drain();
    // Suppressed string of 64 bytes covers the whole 5-byte frame
    wr(SUPP_OFS, 32'h0040_0003);
    @(posedge sys_clk_in);
    `CHK("pkt_crc", pkt_crc_send_out, 1'b0)
    wr(SUPP_OFS, 32'h0004_0003);
    @(posedge sys_clk_in);
    `CHK("pkt_crc", pkt_crc_send_out, 1'b1)
    wr(CTRL_OFS, 32'h0000_0007);
    key_msg_in <= 1'b1;
    repeat (2) @(posedge sys_clk_in);
    `CHK("concat_ok", concat_ok_out, 1'b0)
    key_msg_in <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
    `CHK("concat_ok", concat_ok_out, 1'b1)
    close_out();
  end
endmodule : upstream_fragmenter_and_suppressor_bench
